// ---- hdl/pwm_current_out.sv ----
// pwm relay drive, scaled current setpoint and hysteresis comparator, ahb-lite slave
`timescale 1ns/1ps
module pwm_current_out #(
  parameter int unsigned TICK_CYCLES = pwm_scaler_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] src_value,
  input wire logic src_err,
  input wire logic under_range_flag,
  input wire logic over_range_flag,
  output logic pwm_out,
  output logic [15:0] cur_setpoint,
  output logic cmp_out,
  output logic alarm,
  output logic irq
);
  localparam int NW = 34;
  localparam int DW = 17;

  logic [1:0] ctrl_q;
  logic [15:0] pwm_lo_q, pwm_hi_q, pwm_alarm_q, period_q, min_on_q, min_off_q;
  logic [15:0] in_lo_q, in_hi_q, out_lo_q, out_hi_q, out_alarm_q, lvl_q, hyst_q;
  logic [pwm_scaler_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic wr_pend_q, rd_clr, acc, mapped;
  logic [7:0] wr_addr_q;
  logic [31:0] rd_val;
  logic [31:0] tick_cnt_q;
  logic tick_q, alarm_q, cmp_q, irq_q, start_ev, calc_go;
  logic [15:0] high_ms_q, setpt_q;
  pwm_scaler_pkg::calc_state_t st_q;

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  assign acc = hsel && hready && htrans[1];
  assign mapped = haddr[31:8] == 24'h000000;
  assign rd_clr = acc && !hwrite && mapped && haddr[7:0] == pwm_scaler_pkg::OFS_IRQ_STAT;

  always_comb begin
    rd_val = 32'h00000000;
    if (mapped) begin
      case (haddr[7:0])
        pwm_scaler_pkg::OFS_CTRL: rd_val = {30'h00000000, ctrl_q};
        pwm_scaler_pkg::OFS_PWM_LO: rd_val = {16'h0000, pwm_lo_q};
        pwm_scaler_pkg::OFS_PWM_HI: rd_val = {16'h0000, pwm_hi_q};
        pwm_scaler_pkg::OFS_PWM_ALARM: rd_val = {16'h0000, pwm_alarm_q};
        pwm_scaler_pkg::OFS_PERIOD: rd_val = {16'h0000, period_q};
        pwm_scaler_pkg::OFS_MIN_ON: rd_val = {16'h0000, min_on_q};
        pwm_scaler_pkg::OFS_MIN_OFF: rd_val = {16'h0000, min_off_q};
        pwm_scaler_pkg::OFS_IN_LO: rd_val = {16'h0000, in_lo_q};
        pwm_scaler_pkg::OFS_IN_HI: rd_val = {16'h0000, in_hi_q};
        pwm_scaler_pkg::OFS_OUT_LO: rd_val = {16'h0000, out_lo_q};
        pwm_scaler_pkg::OFS_OUT_HI: rd_val = {16'h0000, out_hi_q};
        pwm_scaler_pkg::OFS_OUT_ALARM: rd_val = {16'h0000, out_alarm_q};
        pwm_scaler_pkg::OFS_CMP_LEVEL: rd_val = {16'h0000, lvl_q};
        pwm_scaler_pkg::OFS_CMP_HYST: rd_val = {16'h0000, hyst_q};
        pwm_scaler_pkg::OFS_STATUS: begin
          rd_val[pwm_scaler_pkg::STAT_PWM] = pwm_out;
          rd_val[pwm_scaler_pkg::STAT_ALARM] = alarm_q;
          rd_val[pwm_scaler_pkg::STAT_CMP] = cmp_q;
          rd_val[pwm_scaler_pkg::STAT_SETPT +: 16] = setpt_q;
        end
        pwm_scaler_pkg::OFS_IRQ_STAT: rd_val = {29'h00000000, irq_stat_q};
        pwm_scaler_pkg::OFS_IRQ_MASK: rd_val = {29'h00000000, irq_mask_q};
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= acc && hwrite && mapped;
      if (acc) begin
        wr_addr_q <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 2'h0;
      pwm_lo_q <= 16'h0000;
      pwm_hi_q <= 16'h0000;
      pwm_alarm_q <= 16'h0000;
      period_q <= pwm_scaler_pkg::PERIOD_RST;
      min_on_q <= 16'h0000;
      min_off_q <= 16'h0000;
      in_lo_q <= 16'h0000;
      in_hi_q <= 16'h0000;
      out_lo_q <= pwm_scaler_pkg::OUT_LO_RST;
      out_hi_q <= pwm_scaler_pkg::OUT_HI_RST;
      out_alarm_q <= pwm_scaler_pkg::OUT_ALARM_RST;
      lvl_q <= 16'h0000;
      hyst_q <= 16'h0000;
      irq_mask_q <= '0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        pwm_scaler_pkg::OFS_CTRL: ctrl_q <= hwdata[1:0];
        pwm_scaler_pkg::OFS_PWM_LO: pwm_lo_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_PWM_HI: pwm_hi_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_PWM_ALARM: pwm_alarm_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_PERIOD: period_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_MIN_ON: min_on_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_MIN_OFF: min_off_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_IN_LO: in_lo_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_IN_HI: in_hi_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_OUT_LO: out_lo_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_OUT_HI: out_hi_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_OUT_ALARM: out_alarm_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_CMP_LEVEL: lvl_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_CMP_HYST: hyst_q <= hwdata[15:0];
        pwm_scaler_pkg::OFS_IRQ_MASK: irq_mask_q <= hwdata[pwm_scaler_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // alarm, comparator and interrupts
  // ****************************************
  logic alarm_d;
  logic signed [17:0] x18, up_th, dn_th;
  assign alarm_d = src_err || under_range_flag || over_range_flag;
  assign x18 = 18'(signed'(src_value));
  assign up_th = 18'(signed'(lvl_q)) + $signed({2'b00, hyst_q});
  assign dn_th = 18'(signed'(lvl_q)) - $signed({2'b00, hyst_q});

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alarm_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      if (x18 > up_th) begin
        cmp_q <= 1'b1;
      end else if (x18 < dn_th) begin
        cmp_q <= 1'b0;
      end
    end
  end

  assign irq_ev[pwm_scaler_pkg::IRQ_ALARM] = alarm_d && !alarm_q;
  assign irq_ev[pwm_scaler_pkg::IRQ_PERIOD] = start_ev;
  assign irq_ev[pwm_scaler_pkg::IRQ_CMP] = (x18 > up_th && !cmp_q) || (x18 < dn_th && cmp_q);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (rd_clr ? '0 : irq_stat_q) | irq_ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // millisecond tick
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tick_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // duty and current operands
  // ****************************************
  logic signed [16:0] xp, plo, phi, xc, ilo, ihi;
  logic [16:0] p_off, p_span, c_off, c_span;
  logic [15:0] per_eff, c_mag;
  logic p_zero, p_full, c_ok;
  logic [NW-1:0] num_p, num_c, quo_p, quo_c;
  logic [DW-1:0] den_p, den_c;
  logic busy_p, done_p;

  assign xp = alarm_d ? 17'(signed'(pwm_alarm_q)) : 17'(signed'(src_value));
  assign plo = 17'(signed'(pwm_lo_q));
  assign phi = 17'(signed'(pwm_hi_q));
  assign p_zero = xp <= plo;
  assign p_full = !p_zero && xp >= phi;
  assign p_off = 17'(xp - plo);
  assign p_span = 17'(phi - plo);
  assign per_eff = pwm_scaler_pkg::period_floor(period_q);
  assign num_p = (p_zero || p_full) ? '0 : NW'(per_eff) * NW'(p_off);
  assign den_p = (p_zero || p_full) ? 17'h00001 : p_span;

  assign ilo = 17'(signed'(in_lo_q));
  assign ihi = 17'(signed'(in_hi_q));
  assign c_ok = ihi > ilo;
  assign xc = (17'(signed'(src_value)) < ilo) ? ilo :
              (17'(signed'(src_value)) > ihi) ? ihi : 17'(signed'(src_value));
  assign c_off = 17'(xc - ilo);
  assign c_span = 17'(ihi - ilo);
  assign c_mag = (out_hi_q >= out_lo_q) ? out_hi_q - out_lo_q : out_lo_q - out_hi_q;
  assign num_c = c_ok ? NW'(c_mag) * NW'(c_off) : '0;
  assign den_c = c_ok ? c_span : 17'h00001;
  assign calc_go = st_q == pwm_scaler_pkg::ST_IDLE;

  ratio_div #(.NW(NW), .DW(DW)) u_div_p (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(calc_go),
    .num(num_p),
    .den(den_p),
    .busy_q(busy_p),
    .done_q(done_p),
    .quo_q(quo_p)
  );

  ratio_div #(.NW(NW), .DW(DW)) u_div_c (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(calc_go),
    .num(num_c),
    .den(den_c),
    .busy_q(),
    .done_q(),
    .quo_q(quo_c)
  );

  // ****************************************
  // result capture
  // ****************************************
  logic pz_q, pf_q, c_alarm_q, c_neg_q;
  logic [15:0] per_c_q, cur_lin, cur_alm, b_lo, b_hi;
  logic [16:0] cur_raw;

  assign cur_raw = c_neg_q ? 17'(out_lo_q) - 17'(quo_c[15:0]) :
                             17'(out_lo_q) + 17'(quo_c[15:0]);
  assign b_lo = c_neg_q ? out_hi_q : out_lo_q;
  assign b_hi = c_neg_q ? out_lo_q : out_hi_q;
  assign cur_lin = (cur_raw[16] || cur_raw[15:0] < b_lo) ? b_lo :
                   (cur_raw[15:0] > b_hi) ? b_hi : cur_raw[15:0];
  assign cur_alm = (out_alarm_q < pwm_scaler_pkg::ALARM_MIN_UA) ? pwm_scaler_pkg::ALARM_MIN_UA :
                   (out_alarm_q > pwm_scaler_pkg::ALARM_MAX_UA) ? pwm_scaler_pkg::ALARM_MAX_UA :
                   out_alarm_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= pwm_scaler_pkg::ST_IDLE;
      pz_q <= 1'b1;
      pf_q <= 1'b0;
      c_alarm_q <= 1'b0;
      c_neg_q <= 1'b0;
      per_c_q <= 16'h0000;
      high_ms_q <= 16'h0000;
      setpt_q <= 16'h0000;
    end else begin
      unique case (st_q)
        pwm_scaler_pkg::ST_IDLE: begin
          pz_q <= p_zero;
          pf_q <= p_full;
          per_c_q <= per_eff;
          c_alarm_q <= alarm_d;
          c_neg_q <= out_hi_q < out_lo_q;
          st_q <= pwm_scaler_pkg::ST_WAIT;
        end
        pwm_scaler_pkg::ST_WAIT: begin
          if (done_p) begin
            high_ms_q <= pz_q ? 16'h0000 : pf_q ? per_c_q : quo_p[15:0];
            if (!ctrl_q[pwm_scaler_pkg::CTRL_CUR_EN]) begin
              setpt_q <= 16'h0000;
            end else begin
              setpt_q <= c_alarm_q ? cur_alm : cur_lin;
            end
            st_q <= pwm_scaler_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  pwm_timer #(.PW(16)) u_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .en(ctrl_q[pwm_scaler_pkg::CTRL_PWM_EN]),
    .tick(tick_q),
    .period_ms(period_q),
    .high_ms(high_ms_q),
    .min_on(min_on_q),
    .min_off(min_off_q),
    .pwm_out_q(pwm_out),
    .start_q(start_ev)
  );

  assign cur_setpoint = setpt_q;
  assign cmp_out = cmp_q;
  assign alarm = alarm_q;
  assign irq = irq_q;

  // ****************************************
  // checks
  // ****************************************
  a_alarm_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
    (src_err || under_range_flag || over_range_flag) |=> alarm_q)
    else $error("alarm not raised");
  a_zero_duty: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_q == pwm_scaler_pkg::ST_WAIT && done_p && pz_q |=> high_ms_q == 16'h0000)
    else $error("zero duty expected");
  a_full_duty: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_q == pwm_scaler_pkg::ST_WAIT && done_p && pf_q |=> high_ms_q == $past(per_c_q))
    else $error("full duty expected");
  a_alarm_window: assert property (@(posedge ref_clk) disable iff (!resetn)
    done_p && c_alarm_q && ctrl_q[pwm_scaler_pkg::CTRL_CUR_EN] |=>
    setpt_q >= pwm_scaler_pkg::ALARM_MIN_UA && setpt_q <= pwm_scaler_pkg::ALARM_MAX_UA)
    else $error("alarm current outside window");
  a_cur_limits: assert property (@(posedge ref_clk) disable iff (!resetn)
    done_p && !c_alarm_q && ctrl_q[pwm_scaler_pkg::CTRL_CUR_EN] |=>
    setpt_q >= $past(b_lo) && setpt_q <= $past(b_hi))
    else $error("current outside output levels");
  a_cmp_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(cmp_q) |-> $past(x18) > $past(up_th))
    else $error("comparator rose below upper threshold");
  a_cmp_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(cmp_q) |-> $past(x18) < $past(dn_th))
    else $error("comparator fell above lower threshold");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    (|(irq_stat_q & irq_mask_q)) |=> irq_q)
    else $error("interrupt not raised");
endmodule : pwm_current_out

// ---- hdl/pwm_scaler_pkg.sv ----
// constants, register map and shared helpers for the pwm and current scaler
package pwm_scaler_pkg;

  // ****************************************
  // timing and alarm current limits
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [15:0] PERIOD_MIN_MS = 16'h0064;
  localparam logic [15:0] ALARM_MIN_UA = 16'h0BB8;
  localparam logic [15:0] ALARM_MAX_UA = 16'h55F0;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PWM_LO = 8'h04;
  localparam logic [7:0] OFS_PWM_HI = 8'h08;
  localparam logic [7:0] OFS_PWM_ALARM = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_MIN_ON = 8'h14;
  localparam logic [7:0] OFS_MIN_OFF = 8'h18;
  localparam logic [7:0] OFS_IN_LO = 8'h1C;
  localparam logic [7:0] OFS_IN_HI = 8'h20;
  localparam logic [7:0] OFS_OUT_LO = 8'h24;
  localparam logic [7:0] OFS_OUT_HI = 8'h28;
  localparam logic [7:0] OFS_OUT_ALARM = 8'h2C;
  localparam logic [7:0] OFS_CMP_LEVEL = 8'h30;
  localparam logic [7:0] OFS_CMP_HYST = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h40;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_PWM_EN = 0;
  localparam int CTRL_CUR_EN = 1;
  localparam int STAT_PWM = 0;
  localparam int STAT_ALARM = 1;
  localparam int STAT_CMP = 2;
  localparam int STAT_SETPT = 16;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_PERIOD = 1;
  localparam int IRQ_CMP = 2;
  localparam int IRQ_W = 3;
  localparam logic [15:0] PERIOD_RST = 16'h03E8;
  localparam logic [15:0] OUT_LO_RST = 16'h0FA0;
  localparam logic [15:0] OUT_HI_RST = 16'h4E20;
  localparam logic [15:0] OUT_ALARM_RST = 16'h0FA0;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} calc_state_t;

  function automatic logic [15:0] period_floor(input logic [15:0] p);
    period_floor = (p < PERIOD_MIN_MS) ? PERIOD_MIN_MS : p;
  endfunction : period_floor

endpackage : pwm_scaler_pkg

// ---- hdl/ratio_div.sv ----
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module ratio_div #(
  parameter int NW = 34,
  parameter int DW = 17
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic busy_q,
  output logic done_q,
  output logic [NW-1:0] quo_q
);
  logic [DW-1:0] rem_q;
  logic [DW-1:0] den_q;
  logic [$clog2(NW+1)-1:0] cnt_q;
  logic [DW:0] trial;
  logic take;

  assign trial = {rem_q, quo_q[NW-1]};
  assign take = trial >= {1'b0, den_q};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rem_q <= '0;
      den_q <= '0;
      quo_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        quo_q <= num;
        den_q <= den;
        rem_q <= '0;
        cnt_q <= ($clog2(NW+1))'(NW);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= take ? DW'(trial - {1'b0, den_q}) : trial[DW-1:0];
        quo_q <= {quo_q[NW-2:0], take};
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == 1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : ratio_div

// ---- hdl/pwm_timer.sv ----
// period counter and min on/off guarded relay drive
`timescale 1ns/1ps
module pwm_timer #(
  parameter int PW = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic tick,
  input wire logic [PW-1:0] period_ms,
  input wire logic [PW-1:0] high_ms,
  input wire logic [PW-1:0] min_on,
  input wire logic [PW-1:0] min_off,
  output logic pwm_out_q,
  output logic start_q
);
  logic [PW-1:0] pos_q, per_q, hi_q, dwell_q, per_new;
  logic wrap, want, may_sw;

  assign per_new = PW'(pwm_scaler_pkg::period_floor(16'(period_ms)));
  assign wrap = ({1'b0, pos_q} + (PW+1)'(1)) >= {1'b0, per_q};
  assign want = pos_q < hi_q;
  assign may_sw = pwm_out_q ? (dwell_q >= min_on) : (dwell_q >= min_off);

  // ****************************************
  // period position, duty taken at each period start
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= '0;
      per_q <= '0;
      hi_q <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (!en) begin
        pos_q <= '0;
        per_q <= '0;
        hi_q <= '0;
      end else if (tick) begin
        if (wrap) begin
          pos_q <= '0;
          per_q <= per_new;
          hi_q <= (high_ms > per_new) ? per_new : high_ms;
          start_q <= 1'b1;
        end else begin
          pos_q <= pos_q + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // output with minimum dwell
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_out_q <= 1'b0;
      dwell_q <= '1;
    end else if (!en) begin
      pwm_out_q <= 1'b0;
      dwell_q <= '1;
    end else if (tick) begin
      if (want != pwm_out_q && may_sw) begin
        pwm_out_q <= want;
        dwell_q <= '0;
      end else if (dwell_q != '1) begin
        dwell_q <= dwell_q + 1'b1;
      end
    end
  end

  a_min_on_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(pwm_out_q) && $past(en) |-> $past(dwell_q) >= $past(min_on))
    else $error("output fell before minimum on time");
  a_min_off_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(pwm_out_q) |-> $past(dwell_q) >= $past(min_off))
    else $error("output rose before minimum off time");
  a_period_floor: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_q |-> per_q >= PW'(pwm_scaler_pkg::PERIOD_MIN_MS) && pos_q == 0)
    else $error("period below floor");
  a_duty_at_start: assert property (@(posedge ref_clk) disable iff (!resetn)
    en && $past(en) && !$stable(hi_q) |-> start_q)
    else $error("duty changed inside a period");
endmodule : pwm_timer

// ---- sim/relay_load.sv ----
// solid state relay load that totals the on time of its drive
`timescale 1ns/1ps
module relay_load (
  input wire logic ref_clk,
  input wire logic drive,
  input wire logic clr,
  output int on_cycles
);
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      on_cycles <= 0;
    end else if (drive) begin
      on_cycles <= on_cycles + 1;
    end
  end
endmodule : relay_load

// ---- sim/test_proportional_pwm_and_current_scaler.sv ----
// self-checking bench for the pwm and current output block
`timescale 1ns/1ps
module test_proportional_pwm_and_current_scaler;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] src_value = 16'h0;
  logic [2:0] flags = 3'h0;
  logic clr = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] cur_setpoint;
  logic hreadyout, hresp, pwm_out, cmp_out, alarm, irq;
  int on_cycles;
  int err_total = 0;
  int comparisons = 0;

  always #10 ref_clk = ~ref_clk;

  pwm_current_out #(.TICK_CYCLES(10)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .src_value(src_value), .src_err(flags[0]), .under_range_flag(flags[1]),
    .over_range_flag(flags[2]), .pwm_out(pwm_out), .cur_setpoint(cur_setpoint),
    .cmp_out(cmp_out), .alarm(alarm), .irq(irq));

  relay_load i_load (.ref_clk(ref_clk), .drive(pwm_out), .clr(clr), .on_cycles(on_cycles));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_rdy();
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) return;
    end
    err_total++;
    give_verdict();
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    bus(1'b0, pwm_scaler_pkg::OFS_PERIOD, 32'h0);
    chk("period", 32'h000003E8, rd);
    bus(1'b0, 8'h44, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : t_regs

  task automatic t_current();
    logic [15:0] xs [5] = '{16'hFFFB, 16'h0000, 16'h01F4, 16'h03E8, 16'h07D0};
    logic [15:0] ys [5] = '{16'h0FA0, 16'h0FA0, 16'h2EE0, 16'h4E20, 16'h4E20};
    bus(1'b1, pwm_scaler_pkg::OFS_IN_HI, 32'h3E8);
    bus(1'b1, pwm_scaler_pkg::OFS_CTRL, 32'h3);
    for (int i = 0; i < 5; i++) begin
      src_value <= xs[i];
      repeat (80) @(posedge ref_clk);
      chk("current", {16'h0, ys[i]}, {16'h0, cur_setpoint});
    end
  endtask : t_current

  task automatic t_alarm();
    bus(1'b1, pwm_scaler_pkg::OFS_OUT_ALARM, 32'h3E8);
    bus(1'b1, pwm_scaler_pkg::OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      flags <= 3'h1 << i;
      repeat (80) @(posedge ref_clk);
      chk("alarm current", 32'h0BB8, {16'h0, cur_setpoint});
      chk("alarm", 32'h1, {31'h0, alarm});
      chk("irq set", 32'h1, {31'h0, irq});
      bus(1'b0, pwm_scaler_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq status", 32'h1, {31'h0, rd[0]});
      repeat (3) @(posedge ref_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      flags <= 3'h0;
      repeat (80) @(posedge ref_clk);
    end
    bus(1'b1, pwm_scaler_pkg::OFS_IRQ_MASK, 32'h0);
  endtask : t_alarm

  task automatic t_cmp();
    logic [15:0] xs [5] = '{16'h0018, 16'h001E, 16'h0024, 16'h001E, 16'h0018};
    logic es [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    bus(1'b1, pwm_scaler_pkg::OFS_CMP_LEVEL, 32'h1E);
    bus(1'b1, pwm_scaler_pkg::OFS_CMP_HYST, 32'h5);
    for (int i = 0; i < 5; i++) begin
      src_value <= xs[i];
      repeat (3) @(posedge ref_clk);
      chk("cmp", {31'h0, es[i]}, {31'h0, cmp_out});
    end
  endtask : t_cmp

  task automatic t_pwm();
    logic [15:0] xs [4] = '{16'h0019, 16'hFFFB, 16'h00C8, 16'h0019};
    logic [2:0] fs [4] = '{3'h0, 3'h0, 3'h0, 3'h4};
    int ons [4] = '{500, 0, 2000, 1000};
    bus(1'b1, pwm_scaler_pkg::OFS_PERIOD, 32'h32);
    bus(1'b1, pwm_scaler_pkg::OFS_PWM_HI, 32'h64);
    bus(1'b1, pwm_scaler_pkg::OFS_PWM_ALARM, 32'h32);
    // restart the long period left running by the earlier scenarios
    bus(1'b1, pwm_scaler_pkg::OFS_CTRL, 32'h2);
    bus(1'b1, pwm_scaler_pkg::OFS_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      src_value <= xs[i];
      flags <= fs[i];
      repeat (1100) @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (2000) @(posedge ref_clk);
      #1;
      chk("on time", ons[i], on_cycles);
    end
  endtask : t_pwm

  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_regs();
    t_current();
    t_alarm();
    t_cmp();
    t_pwm();
    give_verdict();
  end
endmodule : test_proportional_pwm_and_current_scaler
